// file: rtl/bdru_bank.sv
`default_nettype none
// Function
// - Reads are answered without engineering mode; writes to the bias registers need it.
// - Writing the passcode to address 17 sets the engineering-mode flag.
// - In engineering mode addresses 1 to 6 take ordinary writes.
// - Any other value written to address 17 clears engineering mode at once.
// - Written values last only until the next reset, which reloads the one-time values.
// - Sense DAC registers keep only their low 6 bits; the top two read as zero.
// - The carrier and peaking sense DACs power up at 30 and 34.
// - Gate-offset code zero gives the ceiling voltage; larger codes lower it.
// - The register port works only while the 5 V supply is up.
// - The passcode is E3 hexadecimal.
// - Printed defaults load at reset; the power-up load keeps them only when the one-time memory is blank.
module bdru_bank (
    input  wire logic                                    core_clk,
    input  wire logic                                    sys_rst,
    input  wire logic                                    supply_5v_ok,
    input  wire logic                                    otp_programmed,
    input  wire logic [bdru_pkg::NUM_DAC*bdru_pkg::DATA_W-1:0] otp_dac_values,
    input  wire logic [bdru_pkg::DATA_W-1:0]             temp_code,
    input  wire logic                                    wr_en,
    input  wire logic [bdru_pkg::ADDR_W-1:0]             wr_addr,
    input  wire logic [bdru_pkg::DATA_W-1:0]             wr_data,
    input  wire logic                                    rd_en,
    input  wire logic [bdru_pkg::ADDR_W-1:0]             rd_addr,
    output logic      [bdru_pkg::DATA_W-1:0]             rd_data,
    output logic                                         rd_valid,
    output logic                                         engineering_unlock_mode,
    output logic                                         port_active,
    output logic                                         loading,
    output logic      [bdru_pkg::NUM_DAC*bdru_pkg::DATA_W-1:0] dac_values,
    input  wire logic                                    tx_enable_pin,
    output logic                                         bias_on,
    output logic                                         gate_ground
);
    import bdru_pkg::*;

    logic [DATA_W-1:0] dac_reg  [NUM_DAC];
    logic [DATA_W-1:0] dac_next [NUM_DAC];
    logic              unlock_reg;
    logic              unlock_next;
    logic              load_pend_reg;
    logic              load_pend_next;
    logic              supply_s1_reg;
    logic              supply_s2_reg;
    logic              supply_s1_next;
    logic              supply_s2_next;
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;
    logic              rd_valid_reg;
    logic              rd_valid_next;
    logic              wr_ok;
    logic              pass_wr;
    logic              rd_ok;
    logic [2:0]        rd_idx;
    logic [DATA_W-1:0] load_src [NUM_DAC];

    // The bias switch sits in its own module so that its pin synchroniser
    // stays beside the only logic that reads it.
    bdru_bias_if bias_bus ();

    // ************************************************************
    // Transmit-enable bias switch.
    // ************************************************************
    bdru_txen_ctrl u_txen (
        .core_clk      (core_clk),
        .sys_rst       (sys_rst),
        .tx_enable_pin (tx_enable_pin),
        .bias          (bias_bus.drive)
    );

    assign bias_on     = bias_bus.bias_on;
    assign gate_ground = bias_bus.gate_ground;

    // ************************************************************
    // Supply-good synchroniser.
    // ************************************************************
    // The supply-good pin is not tied to core_clk, so it passes two flops
    // before the access qualification reads it.
    always_comb begin
        supply_s1_next = supply_5v_ok;
        supply_s2_next = supply_s1_reg;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            supply_s1_reg <= 1'b0;
            supply_s2_reg <= 1'b0;
        end else begin
            supply_s1_reg <= supply_s1_next;
            supply_s2_reg <= supply_s2_next;
        end
    end

    // ************************************************************
    // Access qualification.
    // ************************************************************
    // Writes are ignored until the supply is up and the power-up load is done; reads need only the supply.
    // A write in the load cycle would be lost under the load, so it is refused.
    assign wr_ok   = wr_en && supply_s2_reg && !load_pend_reg;
    assign rd_ok   = rd_en && supply_s2_reg;
    assign pass_wr = wr_ok && (wr_addr == ADDR_PASSCODE);

    // ************************************************************
    // DAC registers.
    // ************************************************************
    // One register per DAC address; the sense DACs drop their two top bits
    // on every load and every write, so they can never read back as set.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DAC; gi++) begin : g_dac
            localparam logic [4:0] MY_ADDR = 5'(gi + 1);
            localparam logic       IS_SENSE = (gi == IDX_CARRIER_SENSE)
                                           || (gi == IDX_PEAKING_SENSE);
            localparam logic [7:0] KEEP = IS_SENSE ? SENSE_MASK : 8'hFF;

            // Blank one-time memory selects the printed defaults.
            assign load_src[gi] = otp_programmed
                                ? otp_dac_values[gi*DATA_W +: DATA_W]
                                : DAC_DEFAULTS[gi*DATA_W +: DATA_W];

            always_comb begin
                dac_next[gi] = dac_reg[gi];
                if (load_pend_reg) begin
                    dac_next[gi] = load_src[gi] & KEEP;
                end else if (wr_ok && unlock_reg && (wr_addr == MY_ADDR)) begin
                    dac_next[gi] = wr_data & KEEP;
                end
                // Other writes leave the register untouched.
            end

            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    dac_reg[gi] <= DAC_DEFAULTS[gi*DATA_W +: DATA_W] & KEEP;
                end else begin
                    dac_reg[gi] <= dac_next[gi];
                end
            end

            // Code zero drives the ceiling; higher codes pull toward the floor.
            assign dac_values[gi*DATA_W +: DATA_W] = dac_reg[gi];
        end
    endgenerate

    // ************************************************************
    // Power-up load.
    // ************************************************************
    // The load runs in the first cycle after reset and never again until the
    // next reset, so a reset is the only way back to the one-time values.
    always_comb begin
        load_pend_next = 1'b0;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            load_pend_reg <= RST_LOAD_PEND;
        end else begin
            load_pend_reg <= load_pend_next;
        end
    end

    // ************************************************************
    // Engineering unlock flag.
    // ************************************************************
    // Every write to the passcode address decides the flag afresh, so a wrong
    // code locks the bias registers again at once.
    always_comb begin
        unlock_next = unlock_reg;
        if (pass_wr) begin
            unlock_next = (wr_data == UNLOCK_CODE);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            unlock_reg <= RST_UNLOCK;
        end else begin
            unlock_reg <= unlock_next;
        end
    end

    // ************************************************************
    // Read port.
    // ************************************************************
    // Reads need no unlock; unmapped addresses and the passcode address read
    // as zero. The data holds until the next accepted read.
    assign rd_idx = 3'(rd_addr - ADDR_DAC_FIRST);

    always_comb begin
        rd_valid_next = rd_ok;
        rd_data_next  = rd_data_reg;
        if (rd_ok) begin
            rd_data_next = '0;
            if ((rd_addr >= ADDR_DAC_FIRST) && (rd_addr <= ADDR_DAC_LAST)) begin
                rd_data_next = dac_reg[rd_idx];
            end else if (rd_addr == ADDR_TEMP) begin
                rd_data_next = temp_code;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_data_reg  <= '0;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_data_reg  <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    assign rd_data                 = rd_data_reg;
    assign rd_valid                = rd_valid_reg;
    assign engineering_unlock_mode = unlock_reg;
    assign port_active             = supply_s2_reg;
    assign loading                 = load_pend_reg;
endmodule : bdru_bank
`default_nettype wire

// file: rtl/bdru_bias_if.sv
`default_nettype none
interface bdru_bias_if;
    logic bias_on;
    logic gate_ground;
    modport drive (output bias_on, output gate_ground);
    modport take  (input bias_on, input gate_ground);
endinterface : bdru_bias_if
`default_nettype wire

// file: rtl/bdru_pkg.sv
`default_nettype none
package bdru_pkg;
    localparam int          ADDR_W        = 5;
    localparam int          DATA_W        = 8;
    localparam int          NUM_DAC       = 6;
    localparam int          SENSE_W       = 6;
    // Register addresses.
    localparam logic [4:0]  ADDR_DAC_FIRST = 5'h01;
    localparam logic [4:0]  ADDR_DAC_LAST  = 5'h06;
    localparam logic [4:0]  ADDR_TEMP      = 5'h0F;
    localparam logic [4:0]  ADDR_PASSCODE  = 5'h11;
    localparam logic [7:0]  UNLOCK_CODE    = 8'hE3;
    // Indices of the sense DACs within the DAC array (address minus one).
    localparam int          IDX_CARRIER_SENSE = 0;
    localparam int          IDX_PEAKING_SENSE = 3;
    // Values loaded when the one-time memory is blank, by array index.
    localparam logic [47:0] DAC_DEFAULTS   = {8'h80, 8'h80, 8'h22, 8'h80, 8'h80, 8'h1E};
    localparam logic [7:0]  SENSE_MASK     = 8'h3F;
    // Transmit-enable switching budget.
    localparam int          CLK_PERIOD_PS  = 8000;
    localparam int          TX_SWITCH_NS   = 100;
    localparam int          TX_SWITCH_CYC  = (TX_SWITCH_NS * 1000) / CLK_PERIOD_PS;
    localparam logic        RST_LOAD_PEND  = 1'b1;
    localparam logic        RST_UNLOCK     = 1'b0;
endpackage : bdru_pkg
`default_nettype wire

// file: rtl/bdru_txen_ctrl.sv
`default_nettype none
module bdru_txen_ctrl (
    input  wire logic   core_clk,
    input  wire logic   sys_rst,
    input  wire logic   tx_enable_pin,
    bdru_bias_if.drive  bias
);
    import bdru_pkg::*;

    logic sync1_reg;
    logic sync2_reg;
    logic bias_on_reg;
    logic bias_on_next;

    // ************************************************************
    // Pin synchroniser and bias switch.
    // ************************************************************
    always_comb begin
        bias_on_next = sync2_reg;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync1_reg   <= 1'b0;
            sync2_reg   <= 1'b0;
            bias_on_reg <= 1'b0;
        end else begin
            sync1_reg   <= tx_enable_pin;
            sync2_reg   <= sync1_reg;
            bias_on_reg <= bias_on_next;
        end
    end

    // Gates are grounded whenever the bias is off.
    assign bias.bias_on     = bias_on_reg;
    assign bias.gate_ground = ~bias_on_reg;
endmodule : bdru_txen_ctrl
`default_nettype wire

// file: testbench/bdru_bank_properties.sv
`default_nettype none
module bdru_bank_checker
    import bdru_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        otp_programmed,
    input wire logic [47:0] otp_dac_values,
    input wire logic        wr_en,
    input wire logic [4:0]  wr_addr,
    input wire logic [7:0]  wr_data,
    input wire logic        rd_en,
    input wire logic        rd_valid,
    input wire logic        engineering_unlock_mode,
    input wire logic        port_active,
    input wire logic        loading,
    input wire logic [47:0] dac_values,
    input wire logic        tx_enable_pin,
    input wire logic        bias_on,
    input wire logic        gate_ground
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_acc;
        wr_en && port_active && !loading;
    endsequence
    sequence s_code;
        s_acc ##0 wr_addr == ADDR_PASSCODE;
    endsequence
    read_answer_a: assert property (rd_en && port_active |=> rd_valid)
        else $error("read not answered");
    read_gated_a: assert property (!(rd_en && port_active) |=> !rd_valid)
        else $error("read answered while port idle");
    unlock_set_a: assert property (s_code ##0 wr_data == UNLOCK_CODE |=> engineering_unlock_mode)
        else $error("passcode did not unlock");
    unlock_clear_a: assert property (s_code ##0 wr_data != UNLOCK_CODE |=> !engineering_unlock_mode)
        else $error("wrong code left unlock set");
    locked_drop_a: assert property (s_acc ##0 !engineering_unlock_mode && wr_addr inside {[1:6]}
        |=> $stable(dac_values))
        else $error("locked write changed a DAC");
    unlocked_take_a: assert property (s_acc ##0 engineering_unlock_mode && wr_addr == 5'h02
        |=> dac_values[15:8] == $past(wr_data))
        else $error("unlocked write not taken");
    sense_width_a: assert property (dac_values[7:6] == 2'h0 && dac_values[31:30] == 2'h0)
        else $error("sense DAC top bits set");
    power_load_a: assert property (loading |=> !loading && dac_values ==
        (($past(otp_programmed) ? $past(otp_dac_values) : DAC_DEFAULTS)
        & 48'hFFFF_3FFF_FF3F))
        else $error("power-up load wrong");
    gate_ground_a: assert property (gate_ground == !bias_on)
        else $error("gates not grounded while bias off");
    tx_switch_a: assert property (tx_enable_pin[*6] |-> bias_on)
        else $error("bias not switched on in time");
    tx_off_a: assert property ((!tx_enable_pin)[*6] |-> gate_ground && !bias_on)
        else $error("bias not switched off in time");
endmodule : bdru_bank_checker
bind bdru_bank bdru_bank_checker bdru_bank_checker_i (.core_clk, .sys_rst, .otp_programmed,
    .otp_dac_values, .wr_en, .wr_addr, .wr_data, .rd_en, .rd_valid, .engineering_unlock_mode,
    .port_active, .loading, .dac_values, .tx_enable_pin, .bias_on, .gate_ground);
`default_nettype wire

// file: testbench/bdru_host.sv
`default_nettype none
// ****
// Host on the far side of the register port.
// ****
module bdru_host (
    input  wire logic       core_clk,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    output logic            wr_en,
    output logic [4:0]      wr_addr,
    output logic [7:0]      wr_data,
    output logic            rd_en,
    output logic [4:0]      rd_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wr_en, wr_addr, wr_data, rd_en, rd_addr} = '0;
    // Released lines show the inverse of their last value.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge core_clk) {wr_en, wr_addr, wr_data} = {1'b1, a, d};
        @(negedge core_clk) {wr_en, wr_addr, wr_data} = {1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic v);
        @(negedge core_clk) {rd_en, rd_addr} = {1'b1, a};
        @(negedge core_clk) {d, v, rd_en, rd_addr} = {rd_data, rd_valid, 1'b0, ~a};
    endtask : rd
endmodule : bdru_host
`default_nettype wire

// file: testbench/test_bias_dac_register_unlock.sv
`default_nettype none
module test_bias_dac_register_unlock;
    timeunit 1ns;
    timeprecision 1ps;
    import bdru_pkg::*;
    // Sense DACs at addresses 1 and 4 keep only their low six bits.
    localparam logic [47:0] SENSE_KEEP = 48'hFFFF_3FFF_FF3F;
    logic core_clk = 0, sys_rst = 1, supply_5v_ok = 1, otp_programmed = 0, tx_enable_pin = 0;
    logic [47:0] otp_dac_values = 48'h8899AA2B5C33, dac_values;
    logic [7:0]  temp_code = 8'hA7, rd_data, wr_data, d;
    logic [4:0]  wr_addr, rd_addr;
    logic        wr_en, rd_en, rd_valid, engineering_unlock_mode, port_active, loading;
    logic        bias_on, gate_ground, v;
    int          err_count = 0, checks = 0;
    bdru_bank bdru_bank_i (.core_clk, .sys_rst, .supply_5v_ok, .otp_programmed,
        .otp_dac_values, .temp_code, .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr, .rd_data,
        .rd_valid, .engineering_unlock_mode, .port_active, .loading, .dac_values,
        .tx_enable_pin, .bias_on, .gate_ground);
    bdru_host bdru_host_i (.core_clk, .rd_data, .rd_valid, .wr_en, .wr_addr, .wr_data,
        .rd_en, .rd_addr);
    // ****
    // Shared checks and scenarios.
    // ****
    initial forever #4 core_clk = ~core_clk;
    task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
        checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : chk
    task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
        bdru_host_i.rd(a, d, v);
        chk("rd_valid", 1, v);
        chk("rd_data", e, d);
    endtask : rdchk
    task automatic do_reset();
        sys_rst = 1;
        repeat (10) @(negedge core_clk);
        sys_rst = 0;
        repeat (4) @(negedge core_clk);
    endtask : do_reset
    task automatic t_defaults();
        do_reset();
        chk("dac_values", DAC_DEFAULTS, dac_values);
        rdchk(1, 8'd30);
        rdchk(4, 8'd34);
        rdchk(15, temp_code);
    endtask : t_defaults
    task automatic t_locked();
        otp_programmed = 1;
        do_reset();
        chk("dac_values", otp_dac_values & SENSE_KEEP, dac_values);
        bdru_host_i.wr(3, 8'h5A);
        rdchk(3, otp_dac_values[23:16]);
    endtask : t_locked
    task automatic t_unlock();
        bdru_host_i.wr(17, 8'hE3);
        chk("unlock", 1, engineering_unlock_mode);
        for (int i = 2; i <= 6; i++) bdru_host_i.wr(i[4:0], 8'h10 + i[7:0]);
        for (int i = 2; i <= 6; i++) rdchk(i[4:0], 8'h10 + i[7:0]);
        bdru_host_i.wr(1, 8'hFF);
        rdchk(1, 8'h3F);
        bdru_host_i.wr(5, 8'h00);
        rdchk(5, 8'h00);
    endtask : t_unlock
    task automatic t_relock();
        bdru_host_i.wr(17, 8'hE2);
        chk("unlock", 0, engineering_unlock_mode);
        bdru_host_i.wr(2, 8'hC4);
        rdchk(2, 8'h12);
    endtask : t_relock
    task automatic t_supply();
        do_reset();
        chk("dac_values", otp_dac_values & SENSE_KEEP, dac_values);
        supply_5v_ok = 0;
        repeat (4) @(negedge core_clk);
        chk("port_active", 0, port_active);
        bdru_host_i.rd(1, d, v);
        chk("rd_valid", 0, v);
        supply_5v_ok = 1;
        repeat (4) @(negedge core_clk);
        chk("port_active", 1, port_active);
        rdchk(1, otp_dac_values[7:0] & SENSE_KEEP[7:0]);
    endtask : t_supply
    task automatic t_tx();
        tx_enable_pin = 1;
        repeat (TX_SWITCH_CYC) @(negedge core_clk);
        chk("bias_on", 1, bias_on);
        chk("gate_ground", 0, gate_ground);
        tx_enable_pin = 0;
        repeat (TX_SWITCH_CYC) @(negedge core_clk);
        chk("bias_on", 0, bias_on);
        chk("gate_ground", 1, gate_ground);
    endtask : t_tx
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    initial begin
        #20000;
        err_count++;
        finish_test();
    end
    initial begin
        t_defaults();
        t_locked();
        t_unlock();
        t_relock();
        t_supply();
        t_tx();
        finish_test();
    end
endmodule : test_bias_dac_register_unlock
`default_nettype wire
